/* File: pkg/liujac_pkg.sv */
// shared constants and types for the line-interface transmit / jitter attenuator control
package liujac_pkg;

  // register byte offsets
  localparam logic [7:0] LIUJAC_CTRL_OFF   = 8'h00;
  localparam logic [7:0] LIUJAC_STATUS_OFF = 8'h04;
  localparam logic [7:0] LIUJAC_INFO_OFF   = 8'h08;
  localparam logic [7:0] LIUJAC_PROFILE_OFF = 8'h0C;

  // control register field positions
  localparam int LIUJAC_CTL_STD      = 0;
  localparam int LIUJAC_CTL_BOC_LO   = 1;
  localparam int LIUJAC_CTL_TXSRC_LO = 4;
  localparam int LIUJAC_CTL_LIMDIS   = 7;
  localparam int LIUJAC_CTL_PWRDN    = 8;
  localparam int LIUJAC_CTL_DEPTH    = 9;
  localparam int LIUJAC_CTL_PATH     = 10;
  localparam int LIUJAC_CTL_JADIS    = 11;
  localparam int LIUJAC_CTL_PLLSEL   = 12;
  localparam int LIUJAC_CTL_RXSYNC   = 13;
  localparam int LIUJAC_CTL_TXSYNC   = 14;
  localparam int LIUJAC_CTL_RXBYP    = 15;

  // status bit positions (sticky, cleared by read)
  localparam int LIUJAC_ST_OPEN  = 1;
  localparam int LIUJAC_ST_CLIM  = 2;
  localparam int LIUJAC_ST_TRIP  = 0;

  localparam logic [31:0] LIUJAC_CTRL_RST = 32'h0000_0000;

  // divider ratios of the oversampling clock
  localparam logic [4:0] LIUJAC_DIV_NOM  = 5'h10;
  localparam logic [4:0] LIUJAC_DIV_FAST = 5'h0F;
  localparam logic [4:0] LIUJAC_DIV_SLOW = 5'h11;

  // fifo depths and trip thresholds (unit intervals)
  localparam logic [7:0] LIUJAC_DEPTH_SHALLOW = 8'h20;
  localparam logic [7:0] LIUJAC_DEPTH_DEEP    = 8'h80;
  localparam logic [7:0] LIUJAC_TRIP_SHALLOW  = 8'h1C;
  localparam logic [7:0] LIUJAC_TRIP_DEEP     = 8'h78;

  // decoded line profile
  typedef enum logic [3:0] {
    LIUJAC_E1_75       = 4'h0,
    LIUJAC_E1_120      = 4'h1,
    LIUJAC_E1_75_HRL   = 4'h2,
    LIUJAC_E1_120_HRL  = 4'h3,
    LIUJAC_T1_DSX0     = 4'h4,
    LIUJAC_T1_DSX1     = 4'h5,
    LIUJAC_T1_DSX2     = 4'h6,
    LIUJAC_T1_DSX3     = 4'h7,
    LIUJAC_T1_DSX4     = 4'h8,
    LIUJAC_T1_CSU7P5   = 4'h9,
    LIUJAC_T1_CSU15    = 4'hA,
    LIUJAC_T1_CSU22P5  = 4'hB,
    LIUJAC_PROF_BAD    = 4'hF
  } liujac_profile_t;

  typedef enum logic [1:0] {
    LIUJAC_TXSRC_EXT   = 2'h0,
    LIUJAC_TXSRC_RXCLK = 2'h1,
    LIUJAC_TXSRC_ATTEN_REF_CLOCK = 2'h2
  } liujac_txsrc_t;

  typedef struct packed {
    logic       pos;
    logic       neg;
    logic       clk;
  } liujac_line_t;

endpackage : liujac_pkg

/* File: hw/liujac_ctrl.sv */
`timescale 1ns/100ps
`default_nettype none

module liujac_ctrl
  import liujac_pkg::*;
#(
  parameter int FIFO_MAX = 128
) (
  // apb slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // clocks sampled as enables from outside the domain
  input  wire logic        tx_clock_in,
  input  wire logic        rx_rec_clock,
  input  wire logic        atten_ref_clock,
  input  wire logic        osc_tick,
  // transmit data
  input  wire logic        tx_pos_data,
  input  wire logic        tx_neg_data,
  // receive data
  input  wire logic        rx_pos_data,
  input  wire logic        rx_neg_data,
  // analog sense
  input  wire logic        short_detect,
  input  wire logic        open_detect,
  // line side
  output logic             tx_line_pos,
  output logic             tx_line_neg,
  output logic             tx_line_oe_n,
  output logic             limiter_enable,
  output logic [3:0]       line_profile,
  output logic             pll_enable,
  output logic             rx_sync_mode,
  output logic             rx_out_pos,
  output logic             rx_out_neg,
  output logic             rx_out_clk,
  output logic             synth_ref_clk,
  output logic             atten_read_tick
);

  // synchronisers: first stage read only by second
  logic [8:0] sync1_q, sync2_q, sync3_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= 9'h000;
      sync2_q <= 9'h000;
      sync3_q <= 9'h000;
    end else begin
      sync1_q <= {osc_tick, open_detect, short_detect, rx_neg_data, rx_pos_data,
                  tx_neg_data, tx_pos_data, atten_ref_clock, 1'b0};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  // separate sync for the two clocks feeding the transmit mux
  logic [1:0] clk1_q, clk2_q, clk3_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk1_q <= 2'h0;
      clk2_q <= 2'h0;
      clk3_q <= 2'h0;
    end else begin
      clk1_q <= {rx_rec_clock, tx_clock_in};
      clk2_q <= clk1_q;
      clk3_q <= clk2_q;
    end
  end

  logic txc_s, rxc_s, jac_s, tx_pos_data_s, tx_neg_data_s, rpos_s, rneg_s, short_s, open_s, osc_s;
  logic txc_rise, rxc_rise, osc_rise;
  always_comb begin
    txc_s   = clk2_q[0];
    rxc_s   = clk2_q[1];
    jac_s   = sync2_q[1];
    tx_pos_data_s  = sync2_q[2];
    tx_neg_data_s  = sync2_q[3];
    rpos_s  = sync2_q[4];
    rneg_s  = sync2_q[5];
    short_s = sync2_q[6];
    open_s  = sync2_q[7];
    osc_s   = sync2_q[8];
    txc_rise = txc_s & ~clk3_q[0];
    rxc_rise = rxc_s & ~clk3_q[1];
    osc_rise = osc_s & ~sync3_q[8];
  end

  // control register
  logic [31:0] ctrl_q, ctrl_d;
  logic        apb_wr, apb_rd;
  always_comb begin
    apb_wr = psel & penable & pwrite;
    apb_rd = psel & penable & ~pwrite;
    ctrl_d = ctrl_q;
    if (apb_wr && paddr == LIUJAC_CTRL_OFF) begin
      ctrl_d = {16'h0000, pwdata[15:0]};
    end
  end

  logic             std_t1, lim_dis, pwr_dn, deep, path_tx, ja_dis, pll_sel;
  logic             rx_sync, tx_sync, rx_byp;
  logic [2:0]       boc;
  liujac_txsrc_t    txsrc;
  always_comb begin
    std_t1  = ctrl_q[LIUJAC_CTL_STD];
    boc     = ctrl_q[LIUJAC_CTL_BOC_LO +: 3];
    txsrc   = liujac_txsrc_t'(ctrl_q[LIUJAC_CTL_TXSRC_LO +: 2]);
    lim_dis = ctrl_q[LIUJAC_CTL_LIMDIS];
    pwr_dn  = ctrl_q[LIUJAC_CTL_PWRDN];
    deep    = ctrl_q[LIUJAC_CTL_DEPTH];
    path_tx = ctrl_q[LIUJAC_CTL_PATH];
    ja_dis  = ctrl_q[LIUJAC_CTL_JADIS];
    pll_sel = ctrl_q[LIUJAC_CTL_PLLSEL];
    rx_sync = ctrl_q[LIUJAC_CTL_RXSYNC];
    tx_sync = ctrl_q[LIUJAC_CTL_TXSYNC];
    rx_byp  = ctrl_q[LIUJAC_CTL_RXBYP];
  end

  function automatic liujac_profile_t decode_profile(input logic t1, input logic [2:0] code);
    liujac_profile_t p;
    p = LIUJAC_PROF_BAD;
    if (!t1) begin
      case (code)
        3'h0:    p = LIUJAC_E1_75;
        3'h1:    p = LIUJAC_E1_120;
        3'h4:    p = LIUJAC_E1_75_HRL;
        3'h5:    p = LIUJAC_E1_120_HRL;
        default: p = LIUJAC_PROF_BAD;
      endcase
    end else begin
      case (code)
        3'h0:    p = LIUJAC_T1_DSX0;
        3'h1:    p = LIUJAC_T1_DSX1;
        3'h2:    p = LIUJAC_T1_DSX2;
        3'h3:    p = LIUJAC_T1_DSX3;
        3'h4:    p = LIUJAC_T1_DSX4;
        3'h5:    p = LIUJAC_T1_CSU7P5;
        3'h6:    p = LIUJAC_T1_CSU15;
        default: p = LIUJAC_T1_CSU22P5;
      endcase
    end
    return p;
  endfunction : decode_profile

  // transmit clock selection; gapped clocks are fine since only edges matter
  logic tx_tick;
  logic ja_tick;
  always_comb begin
    case (txsrc)
      LIUJAC_TXSRC_RXCLK: tx_tick = rxc_rise;
      LIUJAC_TXSRC_ATTEN_REF_CLOCK: tx_tick = ja_tick;
      default:            tx_tick = txc_rise;
    endcase
  end

  // attenuator fifo: write on source clock, read on smoothed divided clock
  logic [FIFO_MAX-1:0] fpos_q, fpos_d, fneg_q, fneg_d;
  logic [6:0]  wptr_q, wptr_d, rptr_q, rptr_d;
  logic [7:0]  fill_q, fill_d;
  logic [4:0]  divcnt_q, divcnt_d, divlim_q, divlim_d;
  logic        trip_now;
  logic [7:0]  depth, thr;
  logic        wr_tick, src_pos, src_neg;
  always_comb begin
    depth   = deep ? LIUJAC_DEPTH_DEEP : LIUJAC_DEPTH_SHALLOW;
    thr     = deep ? LIUJAC_TRIP_DEEP : LIUJAC_TRIP_SHALLOW;
    wr_tick = path_tx ? tx_tick : rxc_rise;
    src_pos = path_tx ? tx_pos_data_s : rpos_s;
    src_neg = path_tx ? tx_neg_data_s : rneg_s;
    fpos_d  = fpos_q;
    fneg_d  = fneg_q;
    wptr_d  = wptr_q;
    rptr_d  = rptr_q;
    fill_d  = fill_q;
    divcnt_d = divcnt_q;
    divlim_d = divlim_q;
    ja_tick = 1'b0;
    if (osc_rise) begin
      if (divcnt_q >= divlim_q - 5'h01) begin
        divcnt_d = 5'h00;
        ja_tick  = 1'b1;
        // ratio picked per period from fill excursion around the midpoint
        if (fill_q > (depth >> 1) + (thr >> 1)) begin
          divlim_d = LIUJAC_DIV_FAST;
        end else if (fill_q + (thr >> 1) < (depth >> 1)) begin
          divlim_d = LIUJAC_DIV_SLOW;
        end else begin
          divlim_d = LIUJAC_DIV_NOM;
        end
      end else begin
        divcnt_d = divcnt_q + 5'h01;
      end
    end
    if (wr_tick && fill_q < depth) begin
      fpos_d[wptr_q] = src_pos;
      fneg_d[wptr_q] = src_neg;
      wptr_d = (wptr_q + 7'h01) & 7'(depth - 8'h01);
    end
    if (ja_tick && fill_q != 8'h00) begin
      rptr_d = (rptr_q + 7'h01) & 7'(depth - 8'h01);
    end
    fill_d = fill_q + 8'((wr_tick && fill_q < depth) ? 1 : 0)
                    - 8'((ja_tick && fill_q != 8'h00) ? 1 : 0);
    if (ja_dis) begin
      wptr_d = 7'h00;
      rptr_d = 7'h00;
      fill_d = 8'h00;
    end
    trip_now = (divlim_q != LIUJAC_DIV_NOM) && !ja_dis;
  end

  // outputs and sticky status
  logic [2:0]  stat_q, stat_d;
  logic        tx_pos_data_d, tx_neg_data_d, toe_d, rpos_d, rneg_d, rclk_d, syn_d, sq_q, sq_d;
  logic        fo_pos, fo_neg, ja_rx, ja_tx;
  logic [31:0] rdata_d;
  always_comb begin
    fo_pos = fpos_q[rptr_q];
    fo_neg = fneg_q[rptr_q];
    ja_rx  = !ja_dis && !path_tx;
    ja_tx  = !ja_dis && path_tx;
    // sync clock mode follows the synced master reference, itself a square wave
    sq_d   = jac_s;
    tx_pos_data_d = tx_line_pos;
    tx_neg_data_d = tx_line_neg;
    if (tx_sync) begin
      tx_pos_data_d = sq_q;
      tx_neg_data_d = ~sq_q;
    end else if (ja_tx ? ja_tick : tx_tick) begin
      tx_pos_data_d = ja_tx ? fo_pos : tx_pos_data_s;
      tx_neg_data_d = ja_tx ? fo_neg : tx_neg_data_s;
    end
    toe_d  = pwr_dn;
    if (pwr_dn) begin
      tx_pos_data_d = 1'b0;
      tx_neg_data_d = 1'b0;
    end
    // sync clock on receive input replaces coded data
    rpos_d = rx_sync ? rxc_s : ((ja_rx && !rx_byp) ? fo_pos : rpos_s);
    rneg_d = rx_sync ? 1'b0 : ((ja_rx && !rx_byp) ? fo_neg : rneg_s);
    rclk_d = (ja_rx && !rx_byp) ? (divcnt_q < (divlim_q >> 1)) : rxc_s;
    syn_d  = ja_rx ? (divcnt_q < (divlim_q >> 1)) : rxc_s;
    stat_d = stat_q;
    if (apb_rd && paddr == LIUJAC_STATUS_OFF) begin
      stat_d = 3'h0;
    end
    if (short_s) stat_d[LIUJAC_ST_CLIM] = 1'b1;
    if (open_s)  stat_d[LIUJAC_ST_OPEN] = 1'b1;
    if (trip_now) stat_d[LIUJAC_ST_TRIP] = 1'b1;
    case (paddr)
      LIUJAC_CTRL_OFF:    rdata_d = ctrl_q;
      LIUJAC_STATUS_OFF:  rdata_d = {29'h0, stat_q};
      LIUJAC_INFO_OFF:    rdata_d = {19'h0, divlim_q, fill_q};
      LIUJAC_PROFILE_OFF: rdata_d = {28'h0, decode_profile(std_t1, boc)};
      default:            rdata_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q   <= LIUJAC_CTRL_RST;
      fpos_q   <= '0;
      fneg_q   <= '0;
      wptr_q   <= 7'h00;
      rptr_q   <= 7'h00;
      fill_q   <= 8'h00;
      divcnt_q <= 5'h00;
      divlim_q <= LIUJAC_DIV_NOM;
      stat_q   <= 3'h0;
      sq_q     <= 1'b0;
      tx_line_pos   <= 1'b0;
      tx_line_neg   <= 1'b0;
      tx_line_oe_n  <= 1'b0;
      limiter_enable <= 1'b1;
      line_profile  <= 4'h0;
      pll_enable    <= 1'b0;
      rx_sync_mode  <= 1'b0;
      rx_out_pos    <= 1'b0;
      rx_out_neg    <= 1'b0;
      rx_out_clk    <= 1'b0;
      synth_ref_clk <= 1'b0;
      atten_read_tick <= 1'b0;
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      ctrl_q   <= ctrl_d;
      fpos_q   <= fpos_d;
      fneg_q   <= fneg_d;
      wptr_q   <= wptr_d;
      rptr_q   <= rptr_d;
      fill_q   <= fill_d;
      divcnt_q <= divcnt_d;
      divlim_q <= divlim_d;
      stat_q   <= stat_d;
      sq_q     <= sq_d;
      tx_line_pos   <= tx_pos_data_d;
      tx_line_neg   <= tx_neg_data_d;
      tx_line_oe_n  <= toe_d;
      limiter_enable <= ~lim_dis;
      line_profile  <= decode_profile(std_t1, boc);
      pll_enable    <= std_t1 & pll_sel;
      rx_sync_mode  <= rx_sync;
      rx_out_pos    <= rpos_d;
      rx_out_neg    <= rneg_d;
      rx_out_clk    <= rclk_d;
      synth_ref_clk <= syn_d;
      atten_read_tick <= ja_tick & ~ja_dis;
      prdata  <= rdata_d;
      pready  <= psel & ~penable;
      pslverr <= 1'b0;
    end
  end

endmodule : liujac_ctrl

`default_nettype wire

/* File: testbench/liujac_ctrl_props.sv */
`timescale 1ns/100ps
`default_nettype none
module liujac_ctrl_chk
  import liujac_pkg::*;
#(
  parameter int FIFO_MAX = 128
) (
  // apb
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // control outputs
  input wire logic        limiter_enable,
  input wire logic        tx_line_oe_n,
  input wire logic        pll_enable,
  input wire logic        rx_sync_mode,
  input wire logic [3:0]  line_profile
);
  logic [15:0] ctl_q;
  logic [15:0] ctl_d;
  logic [1:0]  age_q;
  logic [1:0]  age_d;
  logic        wr_ctl;
  logic        st;
  // outputs are only judged once a write has had three cycles to land
  assign wr_ctl = psel && penable && pready && pwrite && (paddr == LIUJAC_CTRL_OFF);
  assign st = (age_q == 2'h3);
  always_comb begin
    ctl_d = wr_ctl ? pwdata[15:0] : ctl_q;
    age_d = wr_ctl ? 2'h0 : (st ? age_q : age_q + 2'h1);
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_q <= 16'h0000;
      age_q <= 2'h3;
    end else begin
      ctl_q <= ctl_d;
      age_q <= age_d;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  slverr_low_a: assert property (pslverr == 1'b0)
    else $error("slave error raised");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready held too long");
  ready_setup_a: assert property (psel && !penable |=> pready)
    else $error("no ready in access phase");
  limiter_a: assert property (st |-> limiter_enable == !ctl_q[LIUJAC_CTL_LIMDIS])
    else $error("limiter enable wrong");
  powerdown_a: assert property (st |-> tx_line_oe_n == ctl_q[LIUJAC_CTL_PWRDN])
    else $error("driver enable wrong");
  pll_sel_a: assert property (st |-> pll_enable == (ctl_q[0] && ctl_q[LIUJAC_CTL_PLLSEL]))
    else $error("pll enable wrong");
  rx_sync_a: assert property (st |-> rx_sync_mode == ctl_q[LIUJAC_CTL_RXSYNC])
    else $error("sync mode wrong");
  prof_t1_a: assert property (st && ctl_q[0] |-> line_profile == 4'h4 + {1'b0, ctl_q[3:1]})
    else $error("t1 profile wrong");
  prof_e1_a: assert property (st && !ctl_q[0] && !ctl_q[2] |-> line_profile == {2'h0, ctl_q[3], ctl_q[1]})
    else $error("e1 profile wrong");
endmodule : liujac_ctrl_chk
bind liujac_ctrl liujac_ctrl_chk #(.FIFO_MAX(FIFO_MAX)) liujac_ctrl_chk_inst (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .limiter_enable(limiter_enable),
  .tx_line_oe_n(tx_line_oe_n), .pll_enable(pll_enable), .rx_sync_mode(rx_sync_mode),
  .line_profile(line_profile));
`default_nettype wire

/* File: testbench/liujac_far_model.sv */
`timescale 1ns/100ps
`default_nettype none
module liujac_far_model #(
  parameter int TX_HALF  = 24,
  parameter int OSC_HALF = 2
) (
  // controls
  input wire logic  pclk,
  input wire logic  presetn,
  input wire logic  tx_gap,
  input wire logic  short_req,
  input wire logic  open_req,
  // line side stimulus
  output logic      tx_clock_in,
  output logic      rx_rec_clock,
  output logic      atten_ref_clock,
  output logic      osc_tick,
  output logic      tx_pos_data,
  output logic      tx_neg_data,
  output logic      rx_pos_data,
  output logic      rx_neg_data,
  output logic      short_detect,
  output logic      open_detect
);
  int         tx_cnt;
  int         osc_cnt;
  logic [3:0] pat;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {tx_cnt, osc_cnt, pat} <= '0;
      {tx_clock_in, rx_rec_clock, atten_ref_clock, osc_tick} <= 4'h0;
      {short_detect, open_detect} <= 2'h0;
    end else begin
      osc_cnt <= (osc_cnt == OSC_HALF - 1) ? 0 : osc_cnt + 1;
      tx_cnt <= (tx_cnt == TX_HALF - 1) ? 0 : tx_cnt + 1;
      if (osc_cnt == OSC_HALF - 1) osc_tick <= !osc_tick;
      if (tx_cnt == TX_HALF - 1) begin
        atten_ref_clock <= !atten_ref_clock;
        rx_rec_clock <= !rx_rec_clock;
        // a gapped clock simply skips edges
        if (!tx_gap) tx_clock_in <= !tx_clock_in;
        if (tx_clock_in) pat <= {pat[2:0], ~pat[3]};
      end
      short_detect <= short_req;
      open_detect <= open_req;
    end
  end
  // never both rails at once
  assign tx_pos_data = pat[0];
  assign tx_neg_data = pat[2] & ~pat[0];
  assign rx_pos_data = pat[1];
  assign rx_neg_data = pat[3] & ~pat[1];
endmodule : liujac_far_model
`default_nettype wire

/* File: testbench/liujac_ctrl_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module liujac_ctrl_tb
  import liujac_pkg::*;
();
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        tx_gap = 1'b0, short_req = 1'b0, open_req = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, txc, rxc, jac, osc, tp, tn, rp, rn, sd, od;
  logic        lpos, lneg, oe_n, lim_en, pll_en, rsync, rop, ron, roc, synth, ratk;
  logic [3:0]  prof;
  int          mismatches = 0, samples_checked = 0, cyc = 0;
  int          rises = 0, ticks = 0;
  logic        prev_lpos;
  always #5 pclk = ~pclk;
  liujac_far_model liujac_far_model_inst (.pclk(pclk), .presetn(presetn), .tx_gap(tx_gap),
    .short_req(short_req), .open_req(open_req), .tx_clock_in(txc), .rx_rec_clock(rxc),
    .atten_ref_clock(jac), .osc_tick(osc), .tx_pos_data(tp), .tx_neg_data(tn),
    .rx_pos_data(rp), .rx_neg_data(rn), .short_detect(sd), .open_detect(od));
  liujac_ctrl liujac_ctrl_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .tx_clock_in(txc), .rx_rec_clock(rxc),
    .atten_ref_clock(jac), .osc_tick(osc), .tx_pos_data(tp), .tx_neg_data(tn),
    .rx_pos_data(rp), .rx_neg_data(rn), .short_detect(sd), .open_detect(od),
    .tx_line_pos(lpos), .tx_line_neg(lneg), .tx_line_oe_n(oe_n), .limiter_enable(lim_en),
    .line_profile(prof), .pll_enable(pll_en), .rx_sync_mode(rsync), .rx_out_pos(rop),
    .rx_out_neg(ron), .rx_out_clk(roc), .synth_ref_clk(synth), .atten_read_tick(ratk));
  task test_done;
    if (mismatches == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : test_done
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // no timeout of its own: pready ends this wait, or else the bench timeout
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task rd_chk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask : rd_chk
  function automatic logic [3:0] exp_prof(input logic t1, input logic [2:0] b);
    if (t1) return 4'h4 + {1'b0, b};
    case (b)
      3'h0: return LIUJAC_E1_75;
      3'h1: return LIUJAC_E1_120;
      3'h4: return LIUJAC_E1_75_HRL;
      3'h5: return LIUJAC_E1_120_HRL;
      default: return LIUJAC_PROF_BAD;
    endcase
  endfunction : exp_prof
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      chk(32'h0, 32'h1);
      test_done();
    end
  end
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    chk({31'h0, lim_en}, 32'h1);
    chk({31'h0, oe_n}, 32'h0);
    rd_chk(LIUJAC_CTRL_OFF, LIUJAC_CTRL_RST);
    for (int i = 0; i < 16; i++) begin
      apb(1'b1, LIUJAC_CTRL_OFF, 32'(i));
      rd_chk(LIUJAC_PROFILE_OFF, {28'h0, exp_prof(i[0], i[3:1])});
      chk({28'h0, prof}, {28'h0, exp_prof(i[0], i[3:1])});
    end
    apb(1'b1, LIUJAC_CTRL_OFF, 32'h0000_3181);
    repeat (3) @(posedge pclk);
    chk({31'h0, lim_en}, 32'h0);
    chk({31'h0, oe_n}, 32'h1);
    chk({31'h0, pll_en}, 32'h1);
    chk({31'h0, rsync}, 32'h1);
    apb(1'b1, LIUJAC_CTRL_OFF, 32'h0000_1000);
    rd_chk(LIUJAC_CTRL_OFF, 32'h0000_1000);
    chk({31'h0, pll_en}, 32'h0);
    apb(1'b1, 8'h10, 32'hFFFF_FFFF);
    rd_chk(8'h10, 32'h0);
    rd_chk(LIUJAC_CTRL_OFF, 32'h0000_1000);
    // sync clock mode: line pair carries the square wave in antiphase
    apb(1'b1, LIUJAC_CTRL_OFF, 32'h0000_4000);
    repeat (2) @(posedge pclk);
    prev_lpos = lpos;
    for (int k = 0; k < 150; k++) begin
      @(posedge pclk);
      chk({31'h0, lneg}, {31'h0, ~lpos});
      if (lpos && !prev_lpos) rises++;
      if (ratk) ticks++;
      prev_lpos = lpos;
    end
    chk(32'(rises >= 2 && rises <= 4), 32'h1);
    chk(32'(ticks >= 2 && ticks <= 3), 32'h1);
    // attenuator removed: line data follows the transmit pins at each clock rise
    apb(1'b1, LIUJAC_CTRL_OFF, 32'h0000_0800);
    repeat (2) begin
      @(posedge txc);
      repeat (6) @(posedge pclk);
      chk({30'h0, lpos, lneg}, {30'h0, tp, tn});
    end
    // attenuator removed so the trip flag stays out of the way
    apb(1'b1, LIUJAC_CTRL_OFF, 32'h0000_0880);
    // fill starts far below midpoint, so the slow ratio tripped early on
    rd_chk(LIUJAC_STATUS_OFF, 32'h1);
    short_req <= 1'b1;
    repeat (3) @(posedge pclk);
    short_req <= 1'b0;
    repeat (8) @(posedge pclk);
    rd_chk(LIUJAC_STATUS_OFF, 32'h4);
    rd_chk(LIUJAC_STATUS_OFF, 32'h0);
    open_req <= 1'b1;
    repeat (3) @(posedge pclk);
    open_req <= 1'b0;
    repeat (8) @(posedge pclk);
    rd_chk(LIUJAC_STATUS_OFF, 32'h2);
    // with the fifo held empty the divider settles on the slow ratio
    repeat (80) @(posedge pclk);
    rd_chk(LIUJAC_INFO_OFF, 32'h0000_1100);
    test_done();
  end
endmodule : liujac_ctrl_tb
`default_nettype wire
